/* verilog/ptb_map.svh */
`ifndef PTB_MAP_SVH
`define PTB_MAP_SVH

// ************************************************************
// Register map
// ************************************************************
`define PTB_TICK_CONTROL_ADDR 4'h0
`define PTB_CTRL_RESET        8'h00
`define PTB_RD_IDLE           8'h00

// ************************************************************
// Field positions of tick_control
// ************************************************************
`define PTB_BIT_PEND          7
`define PTB_TAP_HI            6
`define PTB_TAP_LO            4
`define PTB_BIT_CLEAR         3
`define PTB_BIT_IE            2
`define PTB_BIT_RUN           1
`define PTB_BIT_SPARE         0

// ************************************************************
// Divider chain
// ************************************************************
`define PTB_STAGES            15
`define PTB_PRESCALE_STAGES   7
`define PTB_CNT_W             22
`define PTB_CNT_ZERO          22'h000000
`define PTB_PRESCALE_SHIFT    5'h07
`define PTB_NO_SHIFT          5'h00

// Tap bit for each select code; the tick fires when this bit rises, or this bit plus 7 in the EXTRA_PRESCALE build
`define PTB_TAP_BIT_0         5'h0E
`define PTB_TAP_BIT_1         5'h0C
`define PTB_TAP_BIT_2         5'h0A
`define PTB_TAP_BIT_3         5'h06
`define PTB_TAP_BIT_4         5'h05
`define PTB_TAP_BIT_5         5'h04
`define PTB_TAP_BIT_6         5'h03
`define PTB_TAP_BIT_7         5'h02

`endif

/* verilog/ptb_pkg.sv */
package ptb_pkg;

    typedef logic [2:0] ptb_tap_t;
    typedef logic [7:0] ptb_byte_t;
    typedef logic [4:0] ptb_bitidx_t;

endpackage

/* verilog/ptb_tick_if.sv */
`timescale 1ns/1ps

interface ptb_tick_if;
    logic              run;
    ptb_pkg::ptb_tap_t tap_sel;
    logic              advance;
    logic              tick;

    modport ctl (
        output run,
        output tap_sel,
        output advance,
        input  tick
    );

    modport div (
        input  run,
        input  tap_sel,
        input  advance,
        output tick
    );
endinterface

/* verilog/ptb_divider.sv */
`timescale 1ns/1ps
`include "ptb_map.svh"

module ptb_divider #(
    parameter bit EXTRA_PRESCALE = 1'b0
) (
    input wire logic mclk,
    input wire logic srst,
    ptb_tick_if.div  tif
);

    // ************************************************************
    // Tap decode
    // ************************************************************
    function automatic ptb_pkg::ptb_bitidx_t tap_base_f(
        input ptb_pkg::ptb_tap_t sel
    );
        ptb_pkg::ptb_bitidx_t b;
        unique case (sel)
            3'h0: b = `PTB_TAP_BIT_0;
            3'h1: b = `PTB_TAP_BIT_1;
            3'h2: b = `PTB_TAP_BIT_2;
            3'h3: b = `PTB_TAP_BIT_3;
            3'h4: b = `PTB_TAP_BIT_4;
            3'h5: b = `PTB_TAP_BIT_5;
            3'h6: b = `PTB_TAP_BIT_6;
            3'h7: b = `PTB_TAP_BIT_7;
        endcase
        return b;
    endfunction

    logic [`PTB_CNT_W-1:0] cnt_reg;
    logic [`PTB_CNT_W-1:0] cnt_next;
    logic [`PTB_CNT_W-1:0] cnt_inc;
    logic                  tick_reg;
    logic                  step;
    logic                  tap_rise;
    ptb_pkg::ptb_bitidx_t  tap_bit;
    ptb_pkg::ptb_bitidx_t  tap_shift;

    // Mask option fixes the extra stages at build time
    assign tap_shift = EXTRA_PRESCALE ? `PTB_PRESCALE_SHIFT
                                      : `PTB_NO_SHIFT;
    assign tap_bit  = tap_base_f(tif.tap_sel) + tap_shift;
    assign step     = tif.run & tif.advance;
    assign cnt_inc  = cnt_reg + 1'b1;
    // Rising tap bit: first tick after half a period, then every period
    assign tap_rise = step & ~cnt_reg[tap_bit] & cnt_inc[tap_bit];
    assign cnt_next = !tif.run ? `PTB_CNT_ZERO
                    : step     ? cnt_inc
                    :            cnt_reg;
    assign tif.tick = tick_reg;

    // ************************************************************
    // Counter chain
    // ************************************************************
    always_ff @(posedge mclk) begin
        if (srst) begin
            cnt_reg  <= `PTB_CNT_ZERO;
            tick_reg <= 1'b0;
        end else begin
            cnt_reg  <= cnt_next;
            tick_reg <= tap_rise;
        end
    end

    // ************************************************************
    // Checks
    // ************************************************************
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (srst);

    logic [`PTB_CNT_W-1:0] low_mask;
    assign low_mask = (`PTB_CNT_W'(1) << tap_bit) - 1'b1;

    property p_hold_zero;
        !tif.run |=> cnt_reg == `PTB_CNT_ZERO;
    endproperty
    a_hold_zero: assert property (p_hold_zero)
        else $error("counter not held at zero while stopped");

    property p_count_step;
        step |=> cnt_reg == `PTB_CNT_W'($past(cnt_reg) + 1'b1);
    endproperty
    a_count_step: assert property (p_count_step)
        else $error("counter did not advance on oscillator edge");

    property p_tick_phase;
        $stable(tif.tap_sel) && tick_reg |->
            cnt_reg[tap_bit] && ((cnt_reg & low_mask) == `PTB_CNT_ZERO);
    endproperty
    a_tick_phase: assert property (p_tick_phase)
        else $error("tick not at the half-period point of the tap");

endmodule

/* verilog/ptb_timebase.sv */
// Added by the designer: the register addresses and the plain strobed port.
`timescale 1ns/1ps
`include "ptb_map.svh"


module ptb_timebase #(
    parameter bit          EXTRA_PRESCALE = 1'b0,
    parameter int unsigned ADDR_W         = 4
) (
    input  wire logic              mclk,
    input  wire logic              srst,
    input  wire logic [ADDR_W-1:0] addr,
    input  wire logic [7:0]        wr_data,
    input  wire logic              wr_en,
    input  wire logic              rd_en,
    output logic      [7:0]        rd_data,
    input  wire logic              oscillator_clock,
    input  wire logic              wait_mode,
    input  wire logic              stop_mode,
    input  wire logic              osc_run_in_stop,
    output logic                   irq_req
);

    // ************************************************************
    // Declarations
    // ************************************************************
    ptb_tick_if tif ();

    logic              osc_meta_reg;
    logic              osc_sync_reg;
    logic              osc_prev_reg;
    logic              osc_edge;
    logic              osc_halted;

    logic              timebase_run_reg;
    logic              timebase_run_next;
    logic              tick_irq_enable_reg;
    logic              tick_irq_enable_next;
    logic              tick_pending_flag_reg;
    logic              tick_pending_flag_next;
    ptb_pkg::ptb_tap_t tap_select_reg;
    ptb_pkg::ptb_tap_t tap_select_next;
    ptb_pkg::ptb_byte_t rd_data_reg;
    ptb_pkg::ptb_byte_t rd_data_next;
    ptb_pkg::ptb_byte_t ctrl_view;
    logic              irq_reg;
    logic              irq_next;

    logic              bus_open;
    logic              addr_hit;
    logic              wr_ctrl;
    logic              rd_ctrl;
    logic              tick_clear;

    // ************************************************************
    // Oscillator edge detect
    // ************************************************************
    // Oscillator is asynchronous to mclk; it must run below mclk/2
    always_ff @(posedge mclk) begin
        if (srst) begin
            osc_meta_reg <= 1'b0;
            osc_sync_reg <= 1'b0;
            osc_prev_reg <= 1'b0;
        end else begin
            osc_meta_reg <= oscillator_clock;
            osc_sync_reg <= osc_meta_reg;
            osc_prev_reg <= osc_sync_reg;
        end
    end

    assign osc_edge   = osc_sync_reg & ~osc_prev_reg;
    // Oscillator gone in stop unless kept alive
    assign osc_halted = stop_mode & ~osc_run_in_stop;

    // ************************************************************
    // Divider chain
    // ************************************************************
    assign tif.run     = timebase_run_reg;
    assign tif.tap_sel = tap_select_reg;
    assign tif.advance = osc_edge & ~osc_halted;

    ptb_divider #(
        .EXTRA_PRESCALE (EXTRA_PRESCALE)
    ) u_divider (
        .mclk (mclk),
        .srst (srst),
        .tif  (tif.div)
    );

    // ************************************************************
    // Register decode
    // ************************************************************
    // CPU cannot reach the register in wait or stop
    assign bus_open   = ~wait_mode & ~stop_mode;
    assign addr_hit   = addr == ADDR_W'(`PTB_TICK_CONTROL_ADDR);
    assign wr_ctrl    = wr_en & bus_open & addr_hit;
    assign rd_ctrl    = rd_en & bus_open & addr_hit;
    assign tick_clear = wr_ctrl & wr_data[`PTB_BIT_CLEAR];

    assign timebase_run_next    = wr_ctrl ? wr_data[`PTB_BIT_RUN]
                                          : timebase_run_reg;
    assign tick_irq_enable_next = wr_ctrl ? wr_data[`PTB_BIT_IE]
                                          : tick_irq_enable_reg;
    assign tap_select_next      = wr_ctrl
                                ? wr_data[`PTB_TAP_HI:`PTB_TAP_LO]
                                : tap_select_reg;
    // Set wins over clear so a tick in the clear cycle survives
    assign tick_pending_flag_next = tif.tick
        | (tick_pending_flag_reg & ~tick_clear);

    assign irq_next = tick_pending_flag_next
                    & tick_irq_enable_next;

    // Clear bit and spare bit read zero
    always_comb begin
        ctrl_view                          = `PTB_CTRL_RESET;
        ctrl_view[`PTB_BIT_PEND]           = tick_pending_flag_reg;
        ctrl_view[`PTB_TAP_HI:`PTB_TAP_LO] = tap_select_reg;
        ctrl_view[`PTB_BIT_CLEAR]          = 1'b0;
        ctrl_view[`PTB_BIT_IE]             = tick_irq_enable_reg;
        ctrl_view[`PTB_BIT_RUN]            = timebase_run_reg;
        ctrl_view[`PTB_BIT_SPARE]          = 1'b0;
    end

    assign rd_data_next = rd_ctrl ? ctrl_view : `PTB_RD_IDLE;

    // ************************************************************
    // Control state
    // ************************************************************
    always_ff @(posedge mclk) begin
        if (srst) begin
            timebase_run_reg      <= 1'b0;
            tick_irq_enable_reg   <= 1'b0;
            tap_select_reg        <= 3'h0;
            tick_pending_flag_reg <= 1'b0;
            rd_data_reg           <= `PTB_RD_IDLE;
            irq_reg               <= 1'b0;
        end else begin
            timebase_run_reg      <= timebase_run_next;
            tick_irq_enable_reg   <= tick_irq_enable_next;
            tap_select_reg        <= tap_select_next;
            tick_pending_flag_reg <= tick_pending_flag_next;
            rd_data_reg           <= rd_data_next;
            irq_reg               <= irq_next;
        end
    end

    assign rd_data = rd_data_reg;
    assign irq_req = irq_reg;

    // ************************************************************
    // Checks
    // ************************************************************
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (srst);

    property p_tick_sets;
        tif.tick |=> tick_pending_flag_reg;
    endproperty
    a_tick_sets: assert property (p_tick_sets)
        else $error("tick did not set the pending flag");

    property p_irq_follows;
        ##1 irq_req == (tick_pending_flag_reg && tick_irq_enable_reg);
    endproperty
    a_irq_follows: assert property (p_irq_follows)
        else $error("interrupt request does not match flag and enable");

    property p_clear_drops;
        tick_pending_flag_reg && tick_clear && !tif.tick
            |=> !tick_pending_flag_reg ##1 !irq_req;
    endproperty
    a_clear_drops: assert property (p_clear_drops)
        else $error("clear write did not drop the flag and request");

    property p_clear_reads_zero;
        rd_ctrl |=> !rd_data[`PTB_BIT_CLEAR] && !rd_data[`PTB_BIT_SPARE];
    endproperty
    a_clear_reads_zero: assert property (p_clear_reads_zero)
        else $error("clear bit read back as one");

    property p_set_wins;
        tif.tick && tick_clear |=> tick_pending_flag_reg;
    endproperty
    a_set_wins: assert property (p_set_wins)
        else $error("tick lost against a clear in the same cycle");

    property p_flag_sticky;
        tick_pending_flag_reg && !tick_clear |=> tick_pending_flag_reg;
    endproperty
    a_flag_sticky: assert property (p_flag_sticky)
        else $error("pending flag dropped without a clear write");

    property p_flag_no_write;
        !tick_pending_flag_reg && !tif.tick |=> !tick_pending_flag_reg;
    endproperty
    a_flag_no_write: assert property (p_flag_no_write)
        else $error("pending flag set without a tick");

    property p_lowpower_locked;
        (wait_mode || stop_mode) && (rd_en || wr_en)
            |=> rd_data == `PTB_RD_IDLE && $stable(timebase_run_reg)
                && $stable(tap_select_reg);
    endproperty
    a_lowpower_locked: assert property (p_lowpower_locked)
        else $error("register reached in wait or stop mode");

    property p_stop_frozen;
        stop_mode && !osc_run_in_stop |-> !tif.advance;
    endproperty
    a_stop_frozen: assert property (p_stop_frozen)
        else $error("chain advanced in stop without oscillator");

    property p_stop_runs;
        stop_mode && osc_run_in_stop && osc_edge |-> tif.advance;
    endproperty
    a_stop_runs: assert property (p_stop_runs)
        else $error("chain halted in stop with oscillator kept");

    // Own disable: the default one would switch this off during reset
    property p_reset_clears;
        @(posedge mclk) disable iff (1'b0)
            srst |=> !timebase_run_reg && !tick_irq_enable_reg && !irq_req;
    endproperty
    a_reset_clears: assert property (p_reset_clears)
        else $error("reset left run or enable set");

    property p_rd_view;
        rd_ctrl |=> rd_data[`PTB_BIT_PEND] == $past(tick_pending_flag_reg)
            && rd_data[`PTB_TAP_HI:`PTB_TAP_LO] == $past(tap_select_reg);
    endproperty
    a_rd_view: assert property (p_rd_view)
        else $error("read data does not show flag and tap");

    property p_rd_idle;
        !rd_ctrl |=> rd_data == `PTB_RD_IDLE;
    endproperty
    a_rd_idle: assert property (p_rd_idle)
        else $error("read data not idle outside a granted read");

    property p_run_write;
        wr_ctrl |=> timebase_run_reg == $past(wr_data[`PTB_BIT_RUN]);
    endproperty
    a_run_write: assert property (p_run_write)
        else $error("run bit did not take the written value");

    property p_irq_stays;
        irq_req && !wr_ctrl |=> irq_req;
    endproperty
    a_irq_stays: assert property (p_irq_stays)
        else $error("interrupt request dropped without a write");

    property p_irq_needs_enable;
        !tick_irq_enable_reg |-> !irq_req;
    endproperty
    a_irq_needs_enable: assert property (p_irq_needs_enable)
        else $error("interrupt request while interrupt disabled");

    property p_cov_tick;
        timebase_run_reg && tif.tick;
    endproperty
    c_cov_tick: cover property (p_cov_tick);

    property p_cov_irq;
        $rose(irq_req) ##[1:50] tick_clear;
    endproperty
    c_cov_irq: cover property (p_cov_irq);

    property p_cov_collide;
        tif.tick && tick_clear;
    endproperty
    c_cov_collide: cover property (p_cov_collide);

    property p_cov_stop_wake;
        stop_mode && osc_run_in_stop && tif.tick;
    endproperty
    c_cov_stop_wake: cover property (p_cov_stop_wake);

    property p_cov_wait_tick;
        wait_mode && tif.tick;
    endproperty
    c_cov_wait_tick: cover property (p_cov_wait_tick);

endmodule

/* tb/ptb_timebase_tb_top.sv */
`timescale 1ns/1ps
`include "ptb_map.svh"

module ptb_timebase_tb_top;

    // ************************************************************
    // Stimulus and observed signals
    // ************************************************************
    logic                mclk;
    logic                srst;
    logic [3:0]          addr;
    ptb_pkg::ptb_byte_t  wr_data;
    logic                wr_en;
    logic                rd_en;
    ptb_pkg::ptb_byte_t  rd_data;
    ptb_pkg::ptb_byte_t  rd_data_x;
    logic                oscillator_clock;
    logic                wait_mode;
    logic                stop_mode;
    logic                osc_run_in_stop;
    logic                irq_req;
    logic                irq_req_x;
    ptb_pkg::ptb_byte_t  rdv;
    ptb_pkg::ptb_byte_t  rdv_x;
    logic                seen;
    int                  fail_count;
    int                  n_checks;
    int unsigned         div_tab [8] = '{32768, 8192, 2048, 128,
                                         64, 32, 16, 8};
    localparam logic [3:0] A = `PTB_TICK_CONTROL_ADDR;

    ptb_timebase #(.EXTRA_PRESCALE(1'b0), .ADDR_W(4)) u_ptb_timebase (
        .mclk(mclk), .srst(srst), .addr(addr), .wr_data(wr_data),
        .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data),
        .oscillator_clock(oscillator_clock), .wait_mode(wait_mode),
        .stop_mode(stop_mode), .osc_run_in_stop(osc_run_in_stop),
        .irq_req(irq_req)
    );

    // Second build with the seven extra prescale stages, sharing the bus
    ptb_timebase #(.EXTRA_PRESCALE(1'b1), .ADDR_W(4)) u_ptb_timebase_x (
        .mclk(mclk), .srst(srst), .addr(addr), .wr_data(wr_data),
        .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data_x),
        .oscillator_clock(oscillator_clock), .wait_mode(wait_mode),
        .stop_mode(stop_mode), .osc_run_in_stop(osc_run_in_stop),
        .irq_req(irq_req_x)
    );

    initial begin
        mclk             = 1'b0;
        srst             = 1'b1;
        addr             = 4'h0;
        wr_data          = 8'h00;
        wr_en            = 1'b0;
        rd_en            = 1'b0;
        oscillator_clock = 1'b0;
        wait_mode        = 1'b0;
        stop_mode        = 1'b0;
        osc_run_in_stop  = 1'b0;
        fail_count       = 0;
        n_checks         = 0;
    end

    always #25 mclk = ~mclk;

    // ************************************************************
    // Tasks
    // ************************************************************
    function automatic ptb_pkg::ptb_byte_t ctl(input ptb_pkg::ptb_tap_t t,
            input logic c, input logic i, input logic r);
        return {1'b0, t, c, i, r, 1'b0};
    endfunction

    task automatic chk(input ptb_pkg::ptb_byte_t s,
                       input ptb_pkg::ptb_byte_t e);
        n_checks++;
        if (s !== e) begin
            $display("wrong value at %0t: seen %0h expected %0h",
                     $time, s, e);
            fail_count++;
        end
    endtask

    task automatic wr(input logic [3:0] a, input ptb_pkg::ptb_byte_t d);
        @(posedge mclk);
        wr_en   <= 1'b1;
        addr    <= a;
        wr_data <= d;
        @(posedge mclk);
        wr_en   <= 1'b0;
    endtask

    task automatic rd(input logic [3:0] a);
        @(posedge mclk);
        rd_en <= 1'b1;
        addr  <= a;
        @(posedge mclk);
        rd_en <= 1'b0;
        #1;
        rdv   = rd_data;
        rdv_x = rd_data_x;
    endtask

    // Oscillator edges; high and low each h bus cycles, then settle
    task automatic pulses(input int n, input int h);
        repeat (n) begin
            @(posedge mclk);
            oscillator_clock <= 1'b1;
            repeat (h) @(posedge mclk);
            oscillator_clock <= 1'b0;
            repeat (h - 1) @(posedge mclk);
        end
        repeat (6) @(posedge mclk);
    endtask

    // Stop, written with the new tap, clears the counter and pending flag before run restarts
    task automatic restart(input ptb_pkg::ptb_tap_t t, input logic i);
        wr(A, ctl(t, 1'b1, i, 1'b0));
        wr(A, ctl(t, 1'b0, i, 1'b1));
    endtask

    task automatic done(input string s);
        $display("test %s finished", s);
    endtask

    task automatic give_verdict;
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // ************************************************************
    // Watchdog: tests need about 24000 cycles
    // ************************************************************
    initial begin
        repeat (60000) @(posedge mclk);
        fail_count++;
        give_verdict();
    end

    // ************************************************************
    // Tests
    // ************************************************************
    initial begin
        repeat (20) @(posedge mclk);
        srst <= 1'b0;
        rd(A);
        chk(rdv, `PTB_CTRL_RESET);
        chk({7'h00, irq_req}, 8'h00);
        done("reset");

        wr(A, 8'hFC);
        rd(A);
        chk(rdv, 8'h74);
        wr(4'h5, 8'hFF);
        rd(4'h5);
        chk(rdv, 8'h00);
        rd(A);
        chk(rdv, 8'h74);
        done("access");

        // Bus clock alone must not advance the chain
        wr(A, 8'h76);
        repeat (100) @(posedge mclk);
        rd(A);
        chk(rdv, 8'h76);
        for (int k = 1; k <= 20; k++) begin
            pulses(1, 4);
            rd(A);
            chk(rdv, (k % 8 == 4) ? 8'hF6 : 8'h76);
            chk({7'h00, irq_req}, (k % 8 == 4) ? 8'h01 : 8'h00);
            if (k % 8 == 4)
                wr(A, 8'h7E);
        end
        done("period");

        restart(3'h7, 1'b0);
        pulses(4, 4);
        rd(A);
        chk(rdv, 8'hF2);
        chk({7'h00, irq_req}, 8'h00);
        wr(A, 8'h76);
        rd(A);
        chk(rdv, 8'hF6);
        chk({7'h00, irq_req}, 8'h01);
        done("enable");

        // Clear writes every cycle across a tick: the tick must show
        restart(3'h7, 1'b1);
        pulses(3, 4);
        seen = 1'b0;
        @(posedge mclk);
        oscillator_clock <= 1'b1;
        wr_en            <= 1'b1;
        addr             <= A;
        wr_data          <= 8'h7E;
        for (int i = 0; i < 12; i++) begin
            @(posedge mclk);
            if (i == 3)
                oscillator_clock <= 1'b0;
            #1;
            seen = seen | irq_req;
        end
        @(posedge mclk);
        wr_en <= 1'b0;
        chk({7'h00, seen}, 8'h01);
        rd(A);
        chk(rdv, 8'h76);
        done("set_wins");

        restart(3'h7, 1'b1);
        @(posedge mclk);
        wait_mode <= 1'b1;
        wr(A, 8'h00);
        rd(A);
        chk(rdv, 8'h00);
        pulses(4, 4);
        wait_mode <= 1'b0;
        rd(A);
        chk(rdv, 8'hF6);
        restart(3'h7, 1'b1);
        @(posedge mclk);
        stop_mode <= 1'b1;
        wr(A, 8'h00);
        rd(A);
        chk(rdv, 8'h00);
        pulses(8, 4);
        stop_mode <= 1'b0;
        rd(A);
        chk(rdv, 8'h76);
        restart(3'h7, 1'b1);
        @(posedge mclk);
        stop_mode       <= 1'b1;
        osc_run_in_stop <= 1'b1;
        pulses(4, 4);
        chk({7'h00, irq_req}, 8'h01);
        stop_mode <= 1'b0;
        rd(A);
        chk(rdv, 8'hF6);
        // Stopped before stop mode: oscillator kept, still no count
        wr(A, ctl(3'h7, 1'b1, 1'b1, 1'b0));
        @(posedge mclk);
        stop_mode <= 1'b1;
        pulses(8, 4);
        stop_mode <= 1'b0;
        rd(A);
        chk(rdv, 8'h74);
        osc_run_in_stop <= 1'b0;
        done("modes");

        // Leftover count from a short run must be wiped by stopping
        for (int c = 0; c < 8; c++) begin
            restart(ptb_pkg::ptb_tap_t'(c), 1'b0);
            pulses(2, 2);
            restart(ptb_pkg::ptb_tap_t'(c), 1'b0);
            if (c == 0) begin
                pulses(8, 2);
                rd(A);
                chk(rdv, 8'h02);
            end else begin
                pulses(div_tab[c] / 2 - 1, 2);
                rd(A);
                chk(rdv, ctl(ptb_pkg::ptb_tap_t'(c), 0, 0, 1));
                pulses(1, 2);
                rd(A);
                chk(rdv, ctl(ptb_pkg::ptb_tap_t'(c), 0, 0, 1) | 8'h80);
            end
        end
        done("taps");

        restart(3'h7, 1'b0);
        pulses(div_tab[7] * 128 / 2 - 1, 2);
        rd(A);
        chk(rdv_x, 8'h72);
        pulses(1, 2);
        rd(A);
        chk(rdv_x, 8'hF2);
        done("prescale");
        give_verdict();
    end

endmodule
